// ===== logic/i2s_txrx_interrupt_control.sv
// Audio serial port: transmit and receive engines, FIFOs, interrupt status.
// Assumes software drives the configuration pins and a codec on the serial lines.
`timescale 1ns/1ps

// -----------------------------------------------
// Synchronous FIFO with valid/ready on both sides
// -----------------------------------------------
module i2s_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic [WIDTH-1:0] i_in_data,
    input wire logic i_in_valid,
    output logic o_in_ready,
    // Drain side
    output logic [WIDTH-1:0] o_out_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [$clog2(DEPTH):0] o_count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // Pointer and count update
    always_comb begin
        push = i_in_valid && (cnt_q != (AW+1)'(DEPTH));
        pop = i_out_ready && (cnt_q != '0);
        wr_d = push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
        rd_d = pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage and pointers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem[wr_q] <= i_in_data;
        end
    end

    assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem[rd_q];
    assign o_count = cnt_q;
endmodule

// -----------------------------------------------
// Per-module bit and word clock time base
// -----------------------------------------------
module i2s_timebase (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Settings
    input wire logic i_enable,
    input wire logic i_mclk_tick,
    input wire logic [7:0] i_sclk_div,
    input wire logic [2:0] i_wire_size,
    input wire logic [1:0] i_format,
    // Serial clocks and bit position
    output logic o_sclk,
    output logic o_lrclk,
    output logic o_fall,
    output logic o_rise,
    output logic [5:0] o_pos
);
    logic [7:0] div_q, div_d;
    logic sclk_q, sclk_d, lr_q, lr_d, fall_q, fall_d, rise_q, rise_d;
    logic [5:0] cnt_q, cnt_d, pos_q, pos_d, w, last;

    // Master clock ticks divide down to bit clock and word position
    always_comb begin
        w = i2s_pkg::size_bits(i_wire_size);
        last = 6'((7'(w) << 1) - 7'h01);
        div_d = div_q;
        sclk_d = sclk_q;
        cnt_d = cnt_q;
        lr_d = lr_q;
        pos_d = pos_q;
        fall_d = 1'b0;
        rise_d = 1'b0;
        if (!i_enable) begin
            // Idle: clocks low, position parked so the first rise is never a slot start
            div_d = 8'h00;
            sclk_d = 1'b0;
            cnt_d = last;
            lr_d = 1'b0;
            pos_d = last;
        end else if (i_mclk_tick) begin
            if (div_q + 8'h01 >= i_sclk_div) begin
                div_d = 8'h00;
                sclk_d = ~sclk_q;
                if (sclk_q) begin
                    fall_d = 1'b1;
                    cnt_d = (cnt_q >= last) ? 6'h00 : cnt_q + 6'h01;
                    // Standard framing has left low and data one bit late
                    lr_d = (i_format == i2s_pkg::FMT_I2S) ? (cnt_d >= w) : (cnt_d < w);
                    pos_d = (i_format == i2s_pkg::FMT_I2S) ? ((cnt_d == 6'h00) ? last : cnt_d - 6'h01) : cnt_d;
                end else begin
                    rise_d = 1'b1;
                end
            end else begin
                div_d = div_q + 8'h01;
            end
        end
    end

    // Time base registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            div_q <= 8'h00;
            sclk_q <= 1'b0;
            cnt_q <= 6'h3F;
            lr_q <= 1'b0;
            pos_q <= 6'h00;
            fall_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            div_q <= div_d;
            sclk_q <= sclk_d;
            cnt_q <= cnt_d;
            lr_q <= lr_d;
            pos_q <= pos_d;
            fall_q <= fall_d;
            rise_q <= rise_d;
        end
    end

    assign o_sclk = sclk_q;
    assign o_lrclk = lr_q;
    assign o_fall = fall_q;
    assign o_rise = rise_q;
    assign o_pos = pos_q;
endmodule

// -----------------------------------------------
// Top: engines, FIFOs, levels and interrupt status
// -----------------------------------------------
module i2s_txrx_interrupt_control (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Master clock source
    input wire logic i_mclk_ext_sel,
    input wire logic i_mclk_pin,
    // Transmit settings
    input wire logic i_tx_enable,
    input wire logic [1:0] i_tx_format,
    input wire logic [1:0] i_tx_mode,
    input wire logic [2:0] i_tx_sample_size,
    input wire logic [2:0] i_tx_wire_size,
    input wire logic [7:0] i_tx_sclk_div,
    input wire logic [4:0] i_tx_limit,
    // Receive settings
    input wire logic i_rx_enable,
    input wire logic [1:0] i_rx_format,
    input wire logic [1:0] i_rx_mode,
    input wire logic [2:0] i_rx_sample_size,
    input wire logic [2:0] i_rx_wire_size,
    input wire logic [7:0] i_rx_sclk_div,
    input wire logic [4:0] i_rx_limit,
    // Interrupt control
    input wire logic [3:0] i_int_enable,
    input wire logic [3:0] i_int_clear,
    // Transmit data stream
    input wire logic [31:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    // Receive data stream
    output logic [31:0] o_rx_data,
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    // Status
    output logic [4:0] o_tx_level,
    output logic [4:0] o_rx_level,
    output logic [3:0] o_raw_status,
    output logic [3:0] o_masked_status,
    output logic o_irq,
    // Serial lines
    output logic o_tx_sclk,
    output logic o_tx_lrclk,
    output logic o_tx_sdata,
    output logic o_rx_sclk,
    output logic o_rx_lrclk,
    input wire logic i_rx_sdata
);
    logic [2:0] mp_q;
    logic [1:0] sd_q;
    logic [7:0] mdiv_q, mdiv_d;
    logic tick_q, tick_d, tx_fall, rx_rise;
    logic [5:0] tx_pos, rx_pos, tw, ts, rw, rs, tsb, rsb;
    logic [31:0] tl_q, tl_d, tr_q, tr_d, sel, acc_q, acc_d, rl_q, rl_d, rx_word, txf_data;
    logic sdo_q, sdo_d, tx_pop, tx_under, txf_valid, rx_push, rx_over, rxf_ready;
    logic [3:0] tx_cnt, rx_cnt, raw_q, raw_d, msk_q, msk_d, ev;
    logic [4:0] tlev_q, tlev_d, rlev_q, rlev_d;
    logic irq_q, irq_d;
    logic live_q, live_d;

    // Which bit of the slot carries sample bit k, MSB first
    function automatic logic [5:0] slot_bit(input logic [1:0] fmt, input logic [5:0] pos,
                                            input logic [5:0] w, input logic [5:0] s);
        logic [5:0] b;
        b = (pos >= w) ? pos - w : pos;
        if (fmt == i2s_pkg::FMT_RIGHT) begin
            slot_bit = (b >= w - s) ? {1'b1, 5'(b - (w - s))} : 6'h00;
        end else begin
            slot_bit = (b < s) ? {1'b1, 5'(b)} : 6'h00;
        end
    endfunction

    // Master clock tick: internal divider or synchronised pin edge, shared by both modules
    always_comb begin
        mdiv_d = (mdiv_q + 8'h01 >= i2s_pkg::MCLK_INT_DIV) ? 8'h00 : mdiv_q + 8'h01;
        tick_d = i_mclk_ext_sel ? (mp_q[1] && !mp_q[2]) : (mdiv_q == 8'h00);
    end

    // Separate time bases keep each module's own settings
    i2s_timebase tx_tb (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_enable(i_tx_enable), .i_mclk_tick(tick_q),
        .i_sclk_div(i_tx_sclk_div), .i_wire_size(i_tx_wire_size), .i_format(i_tx_format),
        .o_sclk(o_tx_sclk), .o_lrclk(o_tx_lrclk), .o_fall(tx_fall), .o_rise(), .o_pos(tx_pos));
    i2s_timebase rx_tb (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_enable(i_rx_enable), .i_mclk_tick(tick_q),
        .i_sclk_div(i_rx_sclk_div), .i_wire_size(i_rx_wire_size), .i_format(i_rx_format),
        .o_sclk(o_rx_sclk), .o_lrclk(o_rx_lrclk), .o_fall(), .o_rise(rx_rise), .o_pos(rx_pos));

    i2s_fifo #(.WIDTH(i2s_pkg::FIFO_WIDTH), .DEPTH(i2s_pkg::FIFO_DEPTH)) tx_fifo (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_in_data(i_tx_data), .i_in_valid(i_tx_valid),
        .o_in_ready(o_tx_ready), .o_out_data(txf_data), .o_out_valid(txf_valid),
        .i_out_ready(tx_pop), .o_count(tx_cnt));
    i2s_fifo #(.WIDTH(i2s_pkg::FIFO_WIDTH), .DEPTH(i2s_pkg::FIFO_DEPTH)) rx_fifo (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_in_data(rx_word), .i_in_valid(rx_push),
        .o_in_ready(rxf_ready), .o_out_data(o_rx_data), .o_out_valid(o_rx_valid),
        .i_out_ready(i_rx_ready), .o_count(rx_cnt));

    // Transmit: fetch samples at slot start, drive one bit per falling edge
    always_comb begin
        tw = i2s_pkg::size_bits(i_tx_wire_size);
        ts = i2s_pkg::size_bits(i_tx_sample_size);
        tl_d = tl_q;
        tr_d = tr_q;
        sdo_d = sdo_q;
        tx_pop = 1'b0;
        tx_under = 1'b0;
        tsb = 6'h00;
        if (!i_tx_enable) begin
            sdo_d = 1'b0;
        end else if (tx_fall) begin
            if (tx_pos == 6'h00 || (i_tx_mode == i2s_pkg::MODE_DUAL && tx_pos == tw)) begin
                tx_pop = txf_valid;
                tx_under = !txf_valid;
                case (i_tx_mode)
                    i2s_pkg::MODE_DUAL: if (tx_pos == 6'h00) tl_d = txf_data; else tr_d = txf_data;
                    i2s_pkg::MODE_COMPACT16: begin
                        tl_d = {16'h0000, txf_data[15:0]};
                        tr_d = {16'h0000, txf_data[31:16]};
                    end
                    i2s_pkg::MODE_COMPACT8: begin
                        tl_d = {24'h000000, txf_data[7:0]};
                        tr_d = {24'h000000, txf_data[15:8]};
                    end
                    default: begin
                        tl_d = txf_data;
                        tr_d = txf_data;
                    end
                endcase
                if (!txf_valid) begin
                    tl_d = (tx_pos == 6'h00) ? 32'h00000000 : tl_d;
                    tr_d = 32'h00000000;
                end
            end
            sel = (tx_pos >= tw) ? tr_d : tl_d;
            tsb = slot_bit(i_tx_format, tx_pos, tw, ts);
            sdo_d = tsb[5] && sel[5'(ts - 6'h01 - {1'b0, tsb[4:0]})];
        end
        sel = (tx_pos >= tw) ? tr_d : tl_d;
    end

    // Receive: shift bits in on rising edges, push words at slot end
    always_comb begin
        rw = i2s_pkg::size_bits(i_rx_wire_size);
        rs = i2s_pkg::size_bits(i_rx_sample_size);
        rsb = slot_bit(i_rx_format, rx_pos, rw, rs);
        acc_d = acc_q;
        rl_d = rl_q;
        rx_word = acc_q;
        rx_push = 1'b0;
        // Live once a slot has been seen from its first bit; stops a partial word after enable
        live_d = i_rx_enable && (live_q || (rx_rise && rx_pos == 6'h00));
        if (i_rx_enable && rx_rise) begin
            acc_d = (rx_pos == 6'h00 || rx_pos == rw) ? 32'h00000000 : acc_q;
            acc_d = rsb[5] ? {acc_d[30:0], sd_q[1]} : acc_d;
            rx_word = acc_d;
            if (rx_pos == rw - 6'h01) begin
                rl_d = acc_d;
                rx_push = (i_rx_mode == i2s_pkg::MODE_DUAL) || (i_rx_mode == i2s_pkg::MODE_MONO);
            end else if (rx_pos == 6'((7'(rw) << 1) - 7'h01)) begin
                rx_push = (i_rx_mode != i2s_pkg::MODE_MONO);
                if (i_rx_mode == i2s_pkg::MODE_COMPACT16) begin
                    rx_word = {acc_d[15:0], rl_q[15:0]};
                end else if (i_rx_mode == i2s_pkg::MODE_COMPACT8) begin
                    rx_word = {16'h0000, acc_d[7:0], rl_q[7:0]};
                end
            end
        end
        rx_push = rx_push && live_q;
        rx_over = rx_push && !rxf_ready;
    end

    // Levels in samples and the sticky interrupt status
    always_comb begin
        tlev_d = (i_tx_mode == i2s_pkg::MODE_DUAL) ? {1'b0, tx_cnt} : {tx_cnt, 1'b0};
        rlev_d = (i_rx_mode == i2s_pkg::MODE_DUAL) ? {1'b0, rx_cnt} : {rx_cnt, 1'b0};
        ev = '0;
        ev[i2s_pkg::INT_RX_ERR] = rx_over;
        ev[i2s_pkg::INT_RX_REQ] = i_rx_enable && (rlev_q > i_rx_limit);
        ev[i2s_pkg::INT_TX_ERR] = tx_under;
        ev[i2s_pkg::INT_TX_REQ] = i_tx_enable && (tlev_q <= i_tx_limit);
        raw_d = (raw_q & ~i_int_clear) | ev;
        msk_d = raw_d & i_int_enable;
        irq_d = |msk_d;
    end

    // Registers of the top level
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mp_q <= 3'h0;
            sd_q <= 2'h0;
            mdiv_q <= 8'h00;
            tick_q <= 1'b0;
            tl_q <= 32'h00000000;
            tr_q <= 32'h00000000;
            sdo_q <= 1'b0;
            acc_q <= 32'h00000000;
            rl_q <= 32'h00000000;
            tlev_q <= 5'h00;
            rlev_q <= 5'h00;
            raw_q <= i2s_pkg::STATUS_RESET;
            msk_q <= i2s_pkg::STATUS_RESET;
            irq_q <= 1'b0;
            live_q <= 1'b0;
        end else begin
            mp_q <= {mp_q[1:0], i_mclk_pin};
            sd_q <= {sd_q[0], i_rx_sdata};
            mdiv_q <= mdiv_d;
            tick_q <= tick_d;
            tl_q <= tl_d;
            tr_q <= tr_d;
            sdo_q <= sdo_d;
            acc_q <= acc_d;
            rl_q <= rl_d;
            tlev_q <= tlev_d;
            rlev_q <= rlev_d;
            raw_q <= raw_d;
            msk_q <= msk_d;
            irq_q <= irq_d;
            live_q <= live_d;
        end
    end

    assign o_tx_sdata = sdo_q;
    assign o_tx_level = tlev_q;
    assign o_rx_level = rlev_q;
    assign o_raw_status = raw_q;
    assign o_masked_status = msk_q;
    assign o_irq = irq_q;

    // -----------------------------------------------
    // Checks
    // -----------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    irq_from_mask_a: assert property (raw_d[1] && i_int_enable[1] |=> o_irq) else $error("irq missing");
    clear_takes_a: assert property (i_int_clear[0] && !rx_over |=> !o_raw_status[0]) else $error("clear lost");
    set_wins_a: assert property (rx_over |=> o_raw_status[0]) else $error("event lost");
    pending_holds_a: assert property (o_raw_status[2] && !i_int_clear[2] |=> o_raw_status[2])
        else $error("status dropped");
    mask_gates_a: assert property (!i_int_enable[3] |=> !o_masked_status[3]) else $error("mask leak");
    rx_off_quiet_a: assert property (!i_rx_enable |-> !rx_push) else $error("capture while off");
    tx_off_quiet_a: assert property (!i_tx_enable |=> ##1 !o_tx_sdata) else $error("send while off");
    level_range_a: assert property (o_rx_level <= i2s_pkg::LEVEL_MAX && o_tx_level <= i2s_pkg::LEVEL_MAX)
        else $error("level range");
    rx_request_a: assert property (i_rx_enable && o_rx_level > i_rx_limit |=> o_raw_status[1])
        else $error("no rx request");
    raw_vs_mask_a: assert property (o_masked_status == (o_raw_status & $past(i_int_enable)))
        else $error("masked status");
endmodule

// ===== shared/i2s_pkg.sv
// Shared constants and helpers of the audio serial port.
// Assumes one 40 MHz reference clock and a synchronous active-high reset.
package i2s_pkg;
    // -----------------------------------------------
    // Framing formats and FIFO packing modes
    // -----------------------------------------------
    localparam logic [1:0] FMT_I2S = 2'h0;
    localparam logic [1:0] FMT_LEFT = 2'h1;
    localparam logic [1:0] FMT_RIGHT = 2'h2;
    localparam logic [1:0] MODE_DUAL = 2'h0;
    localparam logic [1:0] MODE_COMPACT16 = 2'h1;
    localparam logic [1:0] MODE_COMPACT8 = 2'h2;
    localparam logic [1:0] MODE_MONO = 2'h3;
    // -----------------------------------------------
    // Size codes, status bit positions, counts
    // -----------------------------------------------
    localparam logic [2:0] SIZE_32 = 3'h0;
    localparam logic [2:0] SIZE_24 = 3'h1;
    localparam logic [2:0] SIZE_20 = 3'h2;
    localparam logic [2:0] SIZE_16 = 3'h3;
    localparam logic [2:0] SIZE_8 = 3'h4;
    localparam int INT_RX_ERR = 0;
    localparam int INT_RX_REQ = 1;
    localparam int INT_TX_ERR = 2;
    localparam int INT_TX_REQ = 3;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 32;
    localparam logic [4:0] LEVEL_MAX = 5'h10;
    localparam logic [7:0] MCLK_INT_DIV = 8'h02;

    // Bits for a size code; unknown codes fall back to 32
    function automatic logic [5:0] size_bits(input logic [2:0] code);
        case (code)
            SIZE_24: size_bits = 6'h18;
            SIZE_20: size_bits = 6'h14;
            SIZE_16: size_bits = 6'h10;
            SIZE_8: size_bits = 6'h08;
            default: size_bits = 6'h20;
        endcase
    endfunction
endpackage

// ===== test/codec_model.sv
// Behavioural codec on the serial lines: captures transmit words, sends receive words.
// Assumes standard framing, the device as clock master, and the bench's reference clock.
`timescale 1ns/1ps

module codec_model #(
    parameter int W = 32
) (
    // Clock
    input wire logic i_ref_clk,
    // Transmit lines from the device
    input wire logic i_tx_sclk,
    input wire logic i_tx_lrclk,
    input wire logic i_tx_sdata,
    // Receive lines to the device
    input wire logic i_rx_sclk,
    input wire logic i_rx_lrclk,
    output logic o_rx_sdata,
    // Words sent on each channel
    input wire logic [W-1:0] i_left,
    input wire logic [W-1:0] i_right
);
    logic [W-1:0] cap_q[$];
    logic [W-1:0] sr = '0;
    logic [W-1:0] word = '0;
    logic tsc = 1'b0;
    logic tlr = 1'b0;
    logic rsc = 1'b0;
    logic rlr = 1'b0;
    int p = W - 1;
    int idle = 0;

    initial o_rx_sdata = 1'b0;

    // Shift on rising bit clock; a word clock change closes the word
    always @(posedge i_ref_clk) begin
        if (i_tx_sclk && !tsc) begin
            sr = {sr[W-2:0], i_tx_sdata};
            if (i_tx_lrclk != tlr) cap_q.push_back(sr);
            tlr = i_tx_lrclk;
        end
        tsc = i_tx_sclk;
    end

    // One bit per falling bit clock, MSB a bit after the word clock turns
    always @(posedge i_ref_clk) begin
        idle = (i_rx_sclk != rsc) ? 0 : idle + 1;
        if (rsc && !i_rx_sclk) begin
            if (i_rx_lrclk != rlr) begin
                o_rx_sdata <= word[0];
                word = i_rx_lrclk ? i_right : i_left;
                p = W - 1;
            end else begin
                o_rx_sdata <= word[p];
                p = p - 1;
            end
            rlr = i_rx_lrclk;
        end else if (idle > 40) begin
            // Clock stands still: line wanders so stale bits are never seen
            o_rx_sdata <= ~o_rx_sdata;
            word = i_left;
            p = W - 1;
            rlr = 1'b1; // Next fall with the word clock low starts a left word
        end
        rsc = i_rx_sclk;
    end
endmodule

// ===== test/i2s_txrx_interrupt_control_test.sv
// Self-checking bench of the audio serial port: streams, levels, interrupt status.
// Assumes the codec model on the serial lines and a 40 MHz reference clock.
`timescale 1ns/1ps

module i2s_txrx_interrupt_control_test;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_mclk_ext_sel = 1'b0;
    logic i_mclk_pin = 1'b0;
    logic i_tx_enable = 1'b0;
    logic i_rx_enable = 1'b0;
    logic [1:0] i_tx_format = i2s_pkg::FMT_I2S;
    logic [1:0] i_tx_mode = i2s_pkg::MODE_DUAL;
    logic [2:0] size = i2s_pkg::SIZE_32;
    logic [7:0] sclk_div = 8'h01;
    logic [4:0] i_tx_limit = 5'h00;
    logic [4:0] i_rx_limit = 5'h00;
    logic [3:0] i_int_enable = 4'h0;
    logic [3:0] i_int_clear = 4'h0;
    logic [31:0] i_tx_data = 32'h0;
    logic i_tx_valid = 1'b0;
    logic i_rx_ready = 1'b0;
    logic [31:0] left_w = 32'h0;
    logic [31:0] right_w = 32'h0;
    logic [31:0] seed = 32'h46;
    logic [31:0] sent_q[$];
    logic o_tx_ready, o_rx_valid, o_irq, o_tx_sclk, o_tx_lrclk, o_tx_sdata, o_rx_sclk, o_rx_lrclk, rx_sdata;
    logic [31:0] o_rx_data;
    logic [4:0] o_tx_level, o_rx_level;
    logic [3:0] o_raw_status, o_masked_status;
    wire logic [4:0] flg;
    int bad_count = 0;
    int n_checks = 0;

    assign flg = {o_tx_sclk, o_raw_status};

    // Reference clock and a slower external master clock
    always #12.5 i_ref_clk = ~i_ref_clk;
    always #100 i_mclk_pin = ~i_mclk_pin;

    i2s_txrx_interrupt_control dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mclk_ext_sel(i_mclk_ext_sel), .i_mclk_pin(i_mclk_pin),
        .i_tx_enable(i_tx_enable), .i_tx_format(i_tx_format), .i_tx_mode(i_tx_mode),
        .i_tx_sample_size(size), .i_tx_wire_size(size), .i_tx_sclk_div(sclk_div), .i_tx_limit(i_tx_limit),
        .i_rx_enable(i_rx_enable), .i_rx_format(i2s_pkg::FMT_I2S), .i_rx_mode(i2s_pkg::MODE_DUAL),
        .i_rx_sample_size(size), .i_rx_wire_size(size), .i_rx_sclk_div(sclk_div), .i_rx_limit(i_rx_limit),
        .i_int_enable(i_int_enable), .i_int_clear(i_int_clear),
        .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
        .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready),
        .o_tx_level(o_tx_level), .o_rx_level(o_rx_level), .o_raw_status(o_raw_status),
        .o_masked_status(o_masked_status), .o_irq(o_irq), .o_tx_sclk(o_tx_sclk), .o_tx_lrclk(o_tx_lrclk),
        .o_tx_sdata(o_tx_sdata), .o_rx_sclk(o_rx_sclk), .o_rx_lrclk(o_rx_lrclk), .i_rx_sdata(rx_sdata)
    );

    codec_model codec (
        .i_ref_clk(i_ref_clk), .i_tx_sclk(o_tx_sclk), .i_tx_lrclk(o_tx_lrclk), .i_tx_sdata(o_tx_sdata),
        .i_rx_sclk(o_rx_sclk), .i_rx_lrclk(o_rx_lrclk), .o_rx_sdata(rx_sdata),
        .i_left(left_w), .i_right(right_w)
    );

    // ---------------------------------
    // Helpers
    // ---------------------------------
    function automatic logic [31:0] rnd(input logic [31:0] s);
        rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic ticks(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask

    // Bounded wait for a flag; running out ends the run
    task automatic wait_flg(input int b, input int lim);
        int n;
        n = 0;
        while (flg[b] !== 1'b1 && n < lim) begin
            ticks(1);
            n++;
        end
        if (n == lim) begin
            bad_count++;
            close_out();
        end
    endtask

    // Offer a word; valid held until an edge with ready high
    task automatic push(input logic [31:0] d);
        int n;
        n = 0;
        ticks(1);
        i_tx_data = d;
        i_tx_valid = 1'b1;
        while (o_tx_ready !== 1'b1 && n < 40) begin
            ticks(1);
            n++;
        end
        if (n == 40) begin
            bad_count++;
            close_out();
        end
        ticks(1);
        i_tx_valid = 1'b0;
    endtask

    task automatic pulse_clear(input logic [3:0] m);
        i_int_clear = m;
        ticks(1);
        i_int_clear = 4'h0;
        ticks(2);
    endtask

    // ---------------------------------
    // Scenarios
    // ---------------------------------
    initial begin
        ticks(2);
        i_rst = 1'b0;
        chk(32'({o_irq, o_raw_status, o_masked_status}), 0);
        chk(32'({o_tx_level, o_rx_level, o_tx_ready, o_rx_valid}), 32'h2);
        $display("Test reset done");
        // Fill in every packing mode until refused
        for (int m = 0; m < 4; m++) begin
            i_tx_mode = 2'(m);
            for (int k = 1; k <= 9; k++) begin
                seed = rnd(seed);
                if (k <= 8) begin
                    push(seed);
                end else begin
                    // Offer while full; the word must be ignored
                    i_tx_data = seed;
                    i_tx_valid = 1'b1;
                    ticks(1);
                    i_tx_valid = 1'b0;
                end
                ticks(2);
                chk(32'(o_tx_level), (m == 0 ? 1 : 2) * (k > 8 ? 8 : k));
            end
            chk(32'(o_tx_ready), 0);
            i_rst = 1'b1;
            ticks(2);
            i_rst = 1'b0;
        end
        $display("Test fill done");
        // Quiet while disabled, word clock level on the first bit
        i_tx_mode = i2s_pkg::MODE_DUAL;
        size = i2s_pkg::SIZE_16;
        sclk_div = 8'h02;
        for (int f = 0; f < 3; f++) begin
            i_tx_format = 2'(f);
            ticks(30);
            chk(32'({o_tx_sclk, o_tx_lrclk, o_tx_sdata}), 0);
            i_tx_enable = 1'b1;
            wait_flg(4, 60);
            ticks(5); // Past the first fall, before the next rise
            chk(32'(o_tx_lrclk), 32'(f != 0));
            i_tx_enable = 1'b0;
        end
        i_tx_format = i2s_pkg::FMT_I2S;
        size = i2s_pkg::SIZE_32;
        sclk_div = 8'h01;
        pulse_clear(4'hF);
        $display("Test format done");
        // Six words out, request at the limit, then underflow
        i_tx_limit = 5'h04;
        for (int k = 0; k < 6; k++) begin
            seed = rnd(seed);
            sent_q.push_back(seed);
            push(seed);
        end
        ticks(2);
        chk(32'(o_raw_status), 0);
        codec.cap_q.delete();
        i_tx_enable = 1'b1;
        wait_flg(3, 2000);
        chk(32'(o_tx_level), 4);
        wait_flg(2, 2000);
        chk(32'(o_tx_level), 0);
        ticks(300);
        for (int k = 0; k < 6; k++) chk(codec.cap_q[k], sent_q[k]);
        // Every enable mask against the same pending sources
        for (int e = 0; e < 16; e++) begin
            i_int_enable = 4'(e);
            ticks(2);
            chk(32'(o_raw_status), 32'hC);
            chk(32'(o_masked_status), 32'(4'hC & 4'(e)));
            chk(32'(o_irq), 32'((e & 12) != 0));
        end
        pulse_clear(4'h8);
        chk(32'(o_raw_status), 32'hC);
        i_tx_enable = 1'b0;
        ticks(20);
        pulse_clear(4'h4);
        chk(32'(o_raw_status), 32'h8);
        pulse_clear(4'h8);
        chk(32'({o_irq, o_raw_status}), 0);
        $display("Test transmit done");
        // Receive on the external master clock
        seed = rnd(seed);
        left_w = seed;
        seed = rnd(seed);
        right_w = seed;
        i_mclk_ext_sel = 1'b1;
        i_rx_limit = 5'h02;
        ticks(300);
        chk(32'({o_rx_level, o_raw_status}), 0);
        i_rx_enable = 1'b1;
        wait_flg(1, 3000);
        chk(32'(o_rx_level), 3);
        wait_flg(0, 6000);
        chk(32'(o_rx_level), 8);
        chk(32'(o_tx_sclk), 0);
        i_rx_enable = 1'b0;
        for (int k = 0; k < 8; k++) begin
            ticks(1);
            chk(o_rx_data, k % 2 ? right_w : left_w);
            i_rx_ready = 1'b1;
            ticks(1);
            i_rx_ready = 1'b0;
            ticks(2);
            chk(32'(o_rx_level), 7 - k);
        end
        $display("Test receive done");
        close_out();
    end
endmodule
